// File: rtl/pfp_device.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Device end: flash array with its programming port
// ----------------------------------------------------------------
module pfp_device import pfp_pkg::*; #(
  parameter int WRITE_CNT = WRITE_CYCLES,
  parameter logic [7:0] SIG0 = SIG0_DEF,
  parameter logic [7:0] SIG1 = SIG1_DEF,
  parameter logic [7:0] SIG2 = SIG2_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  pfp_link_if.device link,
  output logic busy
);
  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [7:0] mem [0:ARRAY_DEPTH-1]; // Code array
  logic [11:0] addr_reg; // Internal address counter
  logic lock1_reg; // Lock bit one programmed
  logic lock2_reg; // Lock bit two programmed
  logic [7:0] last_reg; // Byte being written
  logic [11:0] last_addr_reg; // Its address
  logic [31:0] tmr_reg; // Self-timer
  logic [1:0] op_reg; // Pending array action
  logic [7:0] rd_reg; // Array read data
  logic [11:0] sig_pad; // Full address, decoded for signatures
  typedef enum logic [1:0] {
    PFP_IDLE = 2'b00,
    PFP_HOLD = 2'b01,
    PFP_BUSY = 2'b10
  } pfp_dst_t;
  pfp_dst_t st_reg;
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] din;
  logic [3:0] ms;
  logic rh, vpp, inc, strb, inc_d, rh_d, strb_d;
  pfp_sync #(.W(15)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d({link.data_host_o, link.mode_sel, link.rst_high, link.rst_vpp,
        link.increment_pulse_pin}),
    .q({din, ms, rh, vpp, inc})
  );
  // Strobe idles high, so its synchroniser resets high: no false edge
  pfp_sync #(.W(1), .RST(1'b1)) u_sync_s (
    .mclk(mclk),
    .reset_n(reset_n),
    .d(link.program_strobe),
    .q(strb)
  );
  // Edge history of synchronised pins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      inc_d <= 1'b0;
      rh_d <= 1'b0;
      strb_d <= 1'b1;
    end else begin
      inc_d <= inc;
      rh_d <= rh;
      strb_d <= strb;
    end
  end
  // ----------------------------------------------------------------
  // Address counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_reg <= ADDR_START;
    end else if (rh && !rh_d) begin
      addr_reg <= ADDR_START;
    end else if (inc && !inc_d) begin
      addr_reg <= addr_reg + 12'h001;
    end
  end
  // ----------------------------------------------------------------
  // Write / erase sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= PFP_IDLE;
      tmr_reg <= '0;
      op_reg <= 2'h0;
      last_reg <= 8'h00;
      last_addr_reg <= 12'h000;
      lock1_reg <= 1'b0;
      lock2_reg <= 1'b0;
      busy <= 1'b0;
    end else begin
      unique case (st_reg)
        PFP_IDLE: begin
          // Decode high-voltage modes on strobe fall
          if (vpp && strb_d && !strb) begin
            st_reg <= PFP_HOLD;
            tmr_reg <= '0;
            last_reg <= din;
            last_addr_reg <= addr_reg;
            op_reg <= (ms == MODE_WRITE_CODE) ? 2'h0 :
                      (ms == MODE_WRITE_LOCK1) ? 2'h1 :
                      (ms == MODE_WRITE_LOCK2) ? 2'h2 : 2'h3;
          end
        end
        PFP_HOLD: begin
          // Strobe width counted for erase
          tmr_reg <= tmr_reg + 32'h1;
          if (strb) begin
            busy <= (ms == MODE_ERASE) ? 1'b0 : 1'b1;
            st_reg <= (op_reg == 2'h3) ? PFP_IDLE : PFP_BUSY;
            tmr_reg <= '0;
            if (op_reg == 2'h3 && ms == MODE_ERASE && tmr_reg >= 32'(ERASE_CYCLES)) begin
              lock1_reg <= 1'b0;
              lock2_reg <= 1'b0;
            end
            if (op_reg == 2'h1 && ms == MODE_WRITE_LOCK1) lock1_reg <= 1'b1;
            if (op_reg == 2'h2 && ms == MODE_WRITE_LOCK2) lock2_reg <= 1'b1;
          end
        end
        PFP_BUSY: begin
          tmr_reg <= tmr_reg + 32'h1;
          if (tmr_reg >= 32'(WRITE_CNT - 1)) begin
            st_reg <= PFP_IDLE;
            busy <= 1'b0;
          end
        end
        default: st_reg <= PFP_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Array write port
  // ----------------------------------------------------------------
  logic erase_now, write_now;
  logic [12:0] er_cnt_reg; // Erase sweep index
  assign erase_now = (st_reg == PFP_HOLD) && strb && (op_reg == 2'h3) &&
                     (ms == MODE_ERASE) && (tmr_reg >= 32'(ERASE_CYCLES));
  assign write_now = (st_reg == PFP_BUSY) && (tmr_reg == 32'h0) && (op_reg == 2'h0) &&
                     !lock1_reg && (ms == MODE_WRITE_CODE);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // Power-up sweep leaves the array erased
      er_cnt_reg <= 13'h0000;
    end else if (erase_now) begin
      er_cnt_reg <= 13'h0000;
    end else if (!er_cnt_reg[12]) begin
      er_cnt_reg <= er_cnt_reg + 13'h0001;
    end
  end
  // Array contents: no reset, erase sweeps one byte per cycle
  always_ff @(posedge mclk) begin
    if (!er_cnt_reg[12]) begin
      mem[er_cnt_reg[11:0]] <= ERASED_BYTE;
    end else if (write_now) begin
      // Programming only clears bits
      mem[last_addr_reg] <= mem[last_addr_reg] & last_reg;
    end
  end
  always_ff @(posedge mclk) begin
    rd_reg <= mem[addr_reg];
  end
  // ----------------------------------------------------------------
  // Read path and data port drive
  // ----------------------------------------------------------------
  assign sig_pad = addr_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link.data_dev_o <= 8'h00;
      link.data_dev_oe <= 1'b0;
    end else begin
      link.data_dev_oe <= 1'b0;
      link.data_dev_o <= 8'h00;
      if (rh && !vpp && strb) begin
        if (ms == MODE_READ_CODE) begin
          link.data_dev_oe <= 1'b1;
          if (st_reg != PFP_IDLE && addr_reg == last_addr_reg) begin
            // Polling returns complement on bit seven
            link.data_dev_o <= {~last_reg[POLL_BIT], 7'h00};
          end else if (!(lock1_reg && lock2_reg)) begin
            link.data_dev_o <= rd_reg;
          end
        end else if (ms == MODE_READ_SIG) begin
          link.data_dev_oe <= 1'b1;
          link.data_dev_o <= (sig_pad == 12'h000) ? SIG0 :
                             (sig_pad == 12'h001) ? SIG1 :
                             (sig_pad == 12'h002) ? SIG2 : 8'h00;
        end
      end
    end
  end
  // Ready/busy pin is busy inverted, one cycle later
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link.ready_busy_pin <= 1'b1;
    end else begin
      link.ready_busy_pin <= ~busy;
    end
  end
endmodule : pfp_device

// File: rtl/pfp_host.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Programmer end: Wishbone slave driving the programming pins
// ----------------------------------------------------------------
module pfp_host import pfp_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  pfp_link_if.host link
);
  typedef enum logic [2:0] {
    PFP_H_IDLE = 3'b000,
    PFP_H_SETUP = 3'b001,
    PFP_H_PULSE = 3'b010,
    PFP_H_WAIT = 3'b011,
    PFP_H_READ = 3'b100
  } pfp_hst_t;
  pfp_hst_t st_reg;
  pfp_op_t op_reg; // Current operation
  logic [7:0] wdata_reg; // Byte to write
  logic [7:0] rdata_reg; // Byte read back
  logic [31:0] cnt_reg; // Phase counter
  logic [1:0] irq_reg; // Sticky: done, read ready
  logic [1:0] mask_reg; // Interrupt mask
  logic [1:0] ev; // Events this cycle
  logic rb_s, go;
  logic [7:0] din_s;
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Ready pin idles high, so its flop resets high
  pfp_sync #(.W(9), .RST(9'h001)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d({link.data_dev_o, link.ready_busy_pin}),
    .q({din_s, rb_s})
  );
  // Mode code for an operation
  function automatic logic [3:0] mode_of(input pfp_op_t op);
    unique case (op)
      PFP_OP_WRITE: mode_of = MODE_WRITE_CODE;
      PFP_OP_LOCK1: mode_of = MODE_WRITE_LOCK1;
      PFP_OP_LOCK2: mode_of = MODE_WRITE_LOCK2;
      PFP_OP_ERASE: mode_of = MODE_ERASE;
      PFP_OP_SIG: mode_of = MODE_READ_SIG;
      default: mode_of = MODE_READ_CODE;
    endcase
  endfunction : mode_of
  assign go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
              (wb_adr_i == REG_CTRL) && wb_dat_i[CTRL_GO] && (st_reg == PFP_H_IDLE);
  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= UNMAPPED;
      wdata_reg <= 8'h00;
      mask_reg <= 2'h0;
      irq_reg <= 2'h0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= UNMAPPED;
      irq_reg <= irq_reg | ev;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && wb_sel_i[0]) begin
          if (wb_adr_i == REG_DATA) wdata_reg <= wb_dat_i[7:0];
          if (wb_adr_i == REG_MASK) mask_reg <= wb_dat_i[1:0];
          // Write one to clear, new event wins
          if (wb_adr_i == REG_IRQ) irq_reg <= (irq_reg & ~wb_dat_i[1:0]) | ev;
        end else if (!wb_we_i) begin
          unique case (wb_adr_i)
            REG_DATA: wb_dat_o <= {24'h0, rdata_reg};
            REG_STAT: wb_dat_o <= {29'h0, rb_s, st_reg != PFP_H_IDLE, 1'b0};
            REG_IRQ: wb_dat_o <= {30'h0, irq_reg};
            REG_MASK: wb_dat_o <= {30'h0, mask_reg};
            default: wb_dat_o <= UNMAPPED;
          endcase
        end
      end
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) irq <= 1'b0;
    else irq <= |((irq_reg | ev) & mask_reg);
  end
  // ----------------------------------------------------------------
  // Pin sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= PFP_H_IDLE;
      op_reg <= PFP_OP_READ;
      cnt_reg <= '0;
      rdata_reg <= 8'h00;
      ev <= 2'h0;
      link.rst_high <= 1'b0;
      link.rst_vpp <= 1'b0;
      link.increment_pulse_pin <= 1'b0;
      link.program_strobe <= 1'b1;
      link.mode_sel <= MODE_READ_CODE;
      link.data_host_o <= 8'h00;
      link.data_host_oe <= 1'b0;
    end else begin
      ev <= 2'h0;
      cnt_reg <= cnt_reg + 32'h1;
      unique case (st_reg)
        PFP_H_IDLE: begin
          if (go) begin
            op_reg <= pfp_op_t'(wb_dat_i[CTRL_OP_LSB +: 3]);
            cnt_reg <= '0;
            st_reg <= PFP_H_SETUP;
            link.rst_high <= 1'b1;
          end
        end
        PFP_H_SETUP: begin
          link.mode_sel <= mode_of(op_reg);
          if (op_reg == PFP_OP_INC || op_reg == PFP_OP_END) begin
            link.increment_pulse_pin <= 1'b1;
            cnt_reg <= '0;
            st_reg <= PFP_H_PULSE;
          end else if (op_reg == PFP_OP_READ || op_reg == PFP_OP_SIG) begin
            cnt_reg <= '0;
            st_reg <= PFP_H_READ;
          end else if (cnt_reg >= 32'(PULSE_CYCLES)) begin
            link.data_host_o <= wdata_reg;
            link.data_host_oe <= 1'b1;
            link.rst_vpp <= 1'b1;
            link.program_strobe <= 1'b0;
            cnt_reg <= '0;
            st_reg <= PFP_H_PULSE;
          end
        end
        PFP_H_PULSE: begin
          if (cnt_reg >= ((op_reg == PFP_OP_ERASE) ? 32'(ERASE_CYCLES + PULSE_CYCLES) :
                          32'(PULSE_CYCLES))) begin
            link.program_strobe <= 1'b1;
            link.increment_pulse_pin <= 1'b0;
            cnt_reg <= '0;
            st_reg <= PFP_H_WAIT;
          end
        end
        PFP_H_WAIT: begin
          // Poll the written byte at logic high while busy
          if (cnt_reg == 32'(PULSE_CYCLES) && op_reg == PFP_OP_WRITE) begin
            link.rst_vpp <= 1'b0;
            link.data_host_oe <= 1'b0;
            link.mode_sel <= MODE_READ_CODE;
          end
          // Finish once the device reports ready
          if (cnt_reg >= 32'(PULSE_CYCLES) && rb_s) begin
            link.rst_vpp <= 1'b0;
            link.data_host_oe <= 1'b0;
            if (op_reg == PFP_OP_END) begin
              // Increment low first, then reset low
              link.rst_high <= 1'b0;
            end
            ev <= 2'h1;
            st_reg <= PFP_H_IDLE;
          end
        end
        PFP_H_READ: begin
          if (cnt_reg >= 32'(PULSE_CYCLES)) begin
            rdata_reg <= din_s;
            ev <= 2'h2;
            st_reg <= PFP_H_IDLE;
          end
        end
        default: st_reg <= PFP_H_IDLE;
      endcase
    end
  end
endmodule : pfp_host

// File: rtl/pfp_link_if.sv
`timescale 1ns/100ps
// Programming pins between programmer and device
interface pfp_link_if;
  logic rst_high;
  logic rst_vpp;
  logic increment_pulse_pin;
  logic program_strobe;
  logic [3:0] mode_sel;
  logic [7:0] data_host_o;
  logic data_host_oe;
  logic [7:0] data_dev_o;
  logic data_dev_oe;
  logic ready_busy_pin;
  modport device (
    input rst_high, rst_vpp, increment_pulse_pin, program_strobe, mode_sel,
    input data_host_o, data_host_oe,
    output data_dev_o, data_dev_oe, ready_busy_pin
  );
  modport host (
    output rst_high, rst_vpp, increment_pulse_pin, program_strobe, mode_sel,
    output data_host_o, data_host_oe,
    input data_dev_o, data_dev_oe, ready_busy_pin
  );
endinterface : pfp_link_if

// File: rtl/pfp_pkg.sv
package pfp_pkg;
  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int ARRAY_DEPTH = 4096;
  localparam logic [11:0] ADDR_START = 12'h000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int POLL_BIT = 7;
  // ----------------------------------------------------------------
  // Mode-select codes, bits {one,two,three,four}
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_WRITE_CODE = 4'h7;
  localparam logic [3:0] MODE_WRITE_LOCK1 = 4'hF;
  localparam logic [3:0] MODE_WRITE_LOCK2 = 4'hC;
  localparam logic [3:0] MODE_ERASE = 4'h8;
  localparam logic [3:0] MODE_READ_CODE = 4'h3;
  localparam logic [3:0] MODE_READ_SIG = 4'h0;
  // ----------------------------------------------------------------
  // Timing, at 125 MHz
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int WRITE_MAX_US = 2000;
  localparam int WRITE_CYCLES = WRITE_MAX_US * CLK_MHZ;
  localparam int ERASE_MS = 10;
  localparam int ERASE_CYCLES = ERASE_MS * 1000 * CLK_MHZ;
  localparam int PULSE_CYCLES = 8;
  // ----------------------------------------------------------------
  // Wishbone register map of the programmer
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_IRQ = 4'hC;
  localparam logic [3:0] REG_MASK = 4'hD;
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam logic [31:0] UNMAPPED = 32'h0000_0000;
  // Arbitrary neutral identity values
  localparam logic [7:0] SIG0_DEF = 8'hA5;
  localparam logic [7:0] SIG1_DEF = 8'h5A;
  localparam logic [7:0] SIG2_DEF = 8'h3C;
  // Programmer operations
  typedef enum logic [2:0] {
    PFP_OP_WRITE = 3'h0,
    PFP_OP_LOCK1 = 3'h1,
    PFP_OP_LOCK2 = 3'h2,
    PFP_OP_ERASE = 3'h3,
    PFP_OP_READ = 3'h4,
    PFP_OP_SIG = 3'h5,
    PFP_OP_INC = 3'h6,
    PFP_OP_END = 3'h7
  } pfp_op_t;
endpackage : pfp_pkg

// File: rtl/pfp_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser bank for pin inputs
module pfp_sync import pfp_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0 // Reset level per bit; matches pin idle levels except device mode_sel, which resets to zero
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= RST;
      q <= RST;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : pfp_sync

// File: verification/parallel_flash_program_port_tb.sv
`timescale 1ns/100ps
module parallel_flash_program_port_tb import pfp_pkg::*; ;
  localparam int WCNT = 50; // Shortened write cycle
  logic mclk;
  logic reset_n;
  logic cyc;
  logic stb;
  logic we;
  logic ack;
  logic irq;
  logic busy;
  logic [3:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] exp_q[$]; // Expected read data
  logic [31:0] msk_q[$]; // Bits that count
  int n_fail = 0;
  int n_tests = 0;
  pfp_link_if pfp_link_if_inst ();
  pfp_device #(.WRITE_CNT(WCNT)) pfp_device_inst (.mclk(mclk), .reset_n(reset_n),
    .link(pfp_link_if_inst.device), .busy(busy));
  pfp_host pfp_host_inst (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq(irq), .link(pfp_link_if_inst.host));
  pfp_props #(.WRITE_CNT(WCNT)) pfp_props_inst (.mclk(mclk), .reset_n(reset_n),
    .rst_high(pfp_link_if_inst.rst_high), .rst_vpp(pfp_link_if_inst.rst_vpp),
    .increment_pulse_pin(pfp_link_if_inst.increment_pulse_pin),
    .program_strobe(pfp_link_if_inst.program_strobe), .mode_sel(pfp_link_if_inst.mode_sel),
    .data_host_o(pfp_link_if_inst.data_host_o), .data_host_oe(pfp_link_if_inst.data_host_oe),
    .data_dev_o(pfp_link_if_inst.data_dev_o), .data_dev_oe(pfp_link_if_inst.data_dev_oe),
    .ready_busy_pin(pfp_link_if_inst.ready_busy_pin));
  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      n_fail++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, expv);
    end
  endtask : check
  // Verdict and end of run
  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  // One classic Wishbone cycle; reads note their expectation
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [31:0] e, input logic [31:0] m, output logic [31:0] q);
    int i;
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    @(posedge mclk);
    while (ack !== 1'b1 && i < 20) begin
      @(posedge mclk);
      i++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (i == 20) begin
      check(32'h0, 32'h1);
      complete_run();
    end
  endtask : wb
  // Launch an operation, poll its done or read-ready flag bit b, optionally clear flags
  task automatic op(input pfp_op_t o, input int b, input logic clr);
    logic [31:0] q;
    int i;
    wb(1'b1, REG_CTRL, {28'h0, o, 1'b1}, 32'h0, 32'h0, q);
    for (i = 0; i < 300; i++) begin
      wb(1'b0, REG_IRQ, 32'h0, 32'h0, 32'h0, q);
      if (q[b] === 1'b1) break;
    end
    if (i == 300) begin
      check(32'h0, 32'h1);
      complete_run();
    end
    if (clr) wb(1'b1, REG_IRQ, 32'h3, 32'h0, 32'h0, q);
  endtask : op
  // Read results, oldest expectation first
  always @(posedge mclk) begin : watch
    logic [31:0] m;
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      m = msk_q.pop_front();
      check(rdat & m, exp_q.pop_front() & m);
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [31:0] q;
    logic [31:0] rng;
    logic [7:0] b0;
    logic [7:0] b1;
    logic i0;
    logic i1;
    reset_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'h1;
    wdat = 32'h0;
    rng = xs(32'hF0B8A0A1);
    b0 = {rng[7:4], 4'h6};
    rng = xs(rng);
    b1 = rng[7:0];
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    wb(1'b0, REG_STAT, 32'h0, 32'h4, 32'h6, q);
    wb(1'b0, 4'h2, 32'h0, UNMAPPED, 32'hFFFFFFFF, q);
    $display("Test reset done");
    // Power-up erase sweep of the array runs first
    repeat (4200) @(posedge mclk);
    wb(1'b1, REG_DATA, {24'h0, b0}, 32'h0, 32'h0, q);
    // Only blank bytes are ever written
    op(PFP_OP_WRITE, 0, 1'b0);
    check({31'h0, busy}, 32'h0);
    wb(1'b0, REG_STAT, 32'h0, 32'h4, 32'h6, q);
    wb(1'b1, REG_MASK, 32'h3, 32'h0, 32'h0, q);
    repeat (3) @(posedge mclk);
    i1 = irq;
    wb(1'b1, REG_MASK, 32'h0, 32'h0, 32'h0, q);
    repeat (3) @(posedge mclk);
    i0 = irq;
    check({31'h0, i1 ^ i0}, 32'h1);
    wb(1'b1, REG_IRQ, 32'h3, 32'h0, 32'h0, q);
    wb(1'b0, REG_IRQ, 32'h0, 32'h0, 32'h3, q);
    check({31'h0, irq}, 32'h0);
    $display("Test write and interrupt done");
    op(PFP_OP_INC, 0, 1'b1);
    wb(1'b1, REG_DATA, {24'h0, b1}, 32'h0, 32'h0, q);
    op(PFP_OP_WRITE, 0, 1'b1);
    op(PFP_OP_END, 0, 1'b1);
    op(PFP_OP_READ, 1, 1'b1);
    wb(1'b0, REG_DATA, 32'h0, {24'h0, b0}, 32'hFF, q);
    op(PFP_OP_INC, 0, 1'b1);
    op(PFP_OP_READ, 1, 1'b1);
    wb(1'b0, REG_DATA, 32'h0, {24'h0, b1}, 32'hFF, q);
    op(PFP_OP_END, 0, 1'b1);
    $display("Test read back done");
    for (int k = 0; k < 3; k++) begin
      op(PFP_OP_SIG, 1, 1'b1);
      q = (k == 0) ? SIG0_DEF : (k == 1) ? SIG1_DEF : SIG2_DEF;
      wb(1'b0, REG_DATA, 32'h0, q, 32'hFF, q);
      op(PFP_OP_INC, 0, 1'b1);
    end
    op(PFP_OP_END, 0, 1'b1);
    $display("Test signature done");
    op(PFP_OP_LOCK1, 0, 1'b1);
    op(PFP_OP_LOCK2, 0, 1'b1);
    op(PFP_OP_END, 0, 1'b1);
    op(PFP_OP_READ, 1, 1'b1);
    wb(1'b0, REG_DATA, 32'h0, 32'h0, 32'h0, q);
    check({31'h0, q[7:0] === b0}, 32'h0);
    $display("Test lock done");
    complete_run();
  end
endmodule : parallel_flash_program_port_tb

// File: verification/pfp_props.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Pin checks on the programming link
// ----------------------------------------------------------------
module pfp_props import pfp_pkg::*; #(
  parameter int WRITE_CNT = 50
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic rst_high,
  input wire logic rst_vpp,
  input wire logic increment_pulse_pin,
  input wire logic program_strobe,
  input wire logic [3:0] mode_sel,
  input wire logic [7:0] data_host_o,
  input wire logic data_host_oe,
  input wire logic [7:0] data_dev_o,
  input wire logic data_dev_oe,
  input wire logic ready_busy_pin
);
  // Busy window bound, synchroniser slack added
  localparam int BUSY_MAX = WRITE_CNT + 20;
  logic [7:0] last_byte_reg; // Byte taken by last strobe
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Byte under write, for the polling check
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      last_byte_reg <= ERASED_BYTE;
    end else if (!program_strobe && rst_vpp && ready_busy_pin) begin
      last_byte_reg <= data_host_o;
    end
  end
  a_busy_after_strobe: assert property ($rose(program_strobe) && rst_vpp
    && ready_busy_pin && mode_sel == MODE_WRITE_CODE |-> ##[1:6] !ready_busy_pin)
    else $error("busy missing after write strobe");
  a_busy_cause: assert property ($fell(ready_busy_pin) |-> program_strobe)
    else $error("busy rose with strobe low");
  a_write_bounded: assert property ($fell(ready_busy_pin)
    |-> ##[1:BUSY_MAX] ready_busy_pin)
    else $error("write cycle too long");
  a_busy_holds: assert property ($fell(ready_busy_pin) |-> !ready_busy_pin [*8])
    else $error("busy ended too soon");
  a_poll_inverts: assert property ((!ready_busy_pin && !rst_vpp
    && mode_sel == MODE_READ_CODE) [*6] ##0 data_dev_oe
    |-> data_dev_o[POLL_BIT] == !last_byte_reg[POLL_BIT])
    else $error("poll bit not inverted");
  a_no_contention: assert property (data_dev_oe |-> !data_host_oe)
    else $error("both ends drive data");
  a_quiet_in_vpp: assert property (rst_vpp [*4] |-> !data_dev_oe)
    else $error("device drives data at vpp");
  a_end_order: assert property ($fell(rst_high)
    |-> !increment_pulse_pin && !rst_vpp)
    else $error("session end out of order");
  c_write: cover property ($fell(ready_busy_pin));
  c_session: cover property ($rose(rst_high));
  c_step: cover property ($rose(increment_pulse_pin));
  c_poll: cover property (!ready_busy_pin && data_dev_oe);
endmodule : pfp_props
